// >>> hdl/feature_id_pkg.sv
// Purpose: constants, types and decode helpers for the feature id register pair
// Assumes: one core clock, requests come from the core's coprocessor access stage
// Notes:   both registers are read-only constants apart from the trace field
package feature_id_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // coprocessor register coordinates
  localparam logic [3:0] CRN_ID_GROUP    = 4'h0;
  localparam logic [3:0] CRM_FEATURE     = 4'h1;
  localparam logic [2:0] OPC1_SYSTEM     = 3'h0;
  localparam logic [2:0] OPC2_PROC_FEAT1 = 3'h1;
  localparam logic [2:0] OPC2_DEBUG_FEAT = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // processor_feature_1 field positions and values
  localparam int         PF1_PROG_LSB = 0;
  localparam int         PF1_SEC_LSB  = 4;
  localparam int         PF1_MCU_LSB  = 8;
  localparam int         PF1_RSVD_LSB = 12;
  localparam logic [3:0] PF1_PROG_VAL = 4'h1;
  localparam logic [3:0] PF1_SEC_VAL  = 4'h1;
  localparam logic [3:0] PF1_MCU_VAL  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // debug_feature_0 field positions and values
  localparam int         DF0_CP_CORE_LSB  = 0;
  localparam int         DF0_CP_SEC_LSB   = 4;
  localparam int         DF0_MM_CORE_LSB  = 8;
  localparam int         DF0_CP_TRACE_LSB = 12;
  localparam int         DF0_MM_TRACE_LSB = 16;
  localparam int         DF0_MCU_LSB      = 20;
  localparam int         DF0_RSVD_LSB     = 24;
  localparam logic [3:0] DF0_CP_CORE_VAL  = 4'h0;
  localparam logic [3:0] DF0_CP_SEC_VAL   = 4'h0;
  localparam logic [3:0] DF0_MM_CORE_VAL  = 4'h4;
  localparam logic [3:0] DF0_CP_TRACE_VAL = 4'h0;
  localparam logic [3:0] DF0_MM_TRACE_ON  = 4'h1;
  localparam logic [3:0] DF0_MM_TRACE_OFF = 4'h0;
  localparam logic [3:0] DF0_MCU_VAL      = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and timing
  localparam logic [31:0] RSP_DATA_RST = 32'h0000_0000;
  localparam logic        CFG_RST      = 1'b0;
  localparam int          RSP_LATENCY  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_PROC1  = 2'b01,
    SEL_DEBUG0 = 2'b10
  } feat_sel_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic       priv;
    logic       secure;
  } cp_req_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic        undef;
    logic [31:0] data;
  } cp_rsp_t;

  // selects which of the two registers a request names
  function automatic feat_sel_t decode_sel(input cp_req_t r);
    feat_sel_t s;
    s = SEL_NONE;
    if (r.valid && r.crn == CRN_ID_GROUP && r.opc1 == OPC1_SYSTEM && r.crm == CRM_FEATURE) begin
      if (r.opc2 == OPC2_PROC_FEAT1) begin
        s = SEL_PROC1;
      end else if (r.opc2 == OPC2_DEBUG_FEAT) begin
        s = SEL_DEBUG0;
      end
    end
    return s;
  endfunction

endpackage

// >>> hdl/feature_access_check.sv
// Purpose: decodes a coprocessor access and judges whether it is legal
// Assumes: request fields are stable for the cycle in which valid is high
// Notes:   purely combinational; the security state never changes the outcome
`timescale 1ns/1ns
module feature_access_check
  import feature_id_pkg::*;
(
  input  wire cp_req_t   req_in,
  output feat_sel_t      sel_out,
  output logic           hit_out,
  output logic           undef_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register select and legality
  always_comb begin
    sel_out   = decode_sel(req_in);
    hit_out   = (sel_out != SEL_NONE);
    // writes are never allowed, user mode may not touch either register
    undef_out = hit_out && (req_in.write || !req_in.priv);
  end

endmodule // feature_access_check

// >>> hdl/feature_words.sv
// Purpose: builds the two feature words from fixed fields and the trace option
// Assumes: trace_on_in is already in the core clock domain and static
// Notes:   one copy of each word serves both security states
`timescale 1ns/1ns
module feature_words
  import feature_id_pkg::*;
(
  input  wire logic        trace_on_in,
  output logic [31:0]      proc1_word_out,
  output logic [31:0]      debug0_word_out
);

  ////////////////////////////////////////////////////////////////////////////
  // processor_feature_1 layout
  always_comb begin
    proc1_word_out = RSP_DATA_RST;
    proc1_word_out[PF1_PROG_LSB +: 4] = PF1_PROG_VAL;
    proc1_word_out[PF1_SEC_LSB +: 4]  = PF1_SEC_VAL;
    proc1_word_out[PF1_MCU_LSB +: 4]  = PF1_MCU_VAL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // debug_feature_0 layout
  always_comb begin
    debug0_word_out = RSP_DATA_RST;
    debug0_word_out[DF0_CP_CORE_LSB +: 4]  = DF0_CP_CORE_VAL;
    debug0_word_out[DF0_CP_SEC_LSB +: 4]   = DF0_CP_SEC_VAL;
    debug0_word_out[DF0_MM_CORE_LSB +: 4]  = DF0_MM_CORE_VAL;
    debug0_word_out[DF0_CP_TRACE_LSB +: 4] = DF0_CP_TRACE_VAL;
    debug0_word_out[DF0_MM_TRACE_LSB +: 4] = trace_on_in ? DF0_MM_TRACE_ON : DF0_MM_TRACE_OFF;
    debug0_word_out[DF0_MCU_LSB +: 4]      = DF0_MCU_VAL;
  end

endmodule // feature_words

// >>> hdl/feature_id_regs.sv
// Purpose: read-only processor and debug feature id registers on the
//          system_control_coprocessor access path
// Assumes: one request per cycle at most; answer one cycle after the request
// Notes:   the trace option is a build strap, synchronised before use
//
// Notes on behaviour
// - Each register exists once and reads the same in secure and nonsecure state.
// - Only privileged modes may read; any user-mode access raises undefined.
// - Every write to either register raises undefined, privileged or not.
// - processor_feature_1 reads zero in [31:12] and 0x0 in the microcontroller field.
// - processor_feature_1 reads 0x1 in the security extensions field [7:4].
// - processor_feature_1 reads 0x1 in the programmer's model field [3:0].
// - debug_feature_0 reads zero in [31:24] and 0x0 in the microcontroller debug field.
// - debug_feature_0 [19:16] reads 0x1 with the trace option and 0x0 without.
// - debug_feature_0 [15:12] reads 0x0, no coprocessor trace model.
// - debug_feature_0 [11:8] reads 0x4, memory-mapped debug model.
// - debug_feature_0 [7:4] reads 0x0, no coprocessor secure debug model.
// - debug_feature_0 [3:0] reads 0x0, no coprocessor core debug model.
`timescale 1ns/1ns
module feature_id_regs
  import feature_id_pkg::*;
(
  input  wire logic     mclk_in,
  input  wire logic     nrst_in,
  input  wire logic     trace_macrocell_option_in,
  input  wire cp_req_t  req_in,
  output cp_rsp_t       rsp_out
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic        trace_meta_q;
  logic        trace_sync_q;
  logic        trace_cfg_q;
  feat_sel_t   sel;
  logic        hit;
  logic        undef;
  logic [31:0] proc1_word;
  logic [31:0] debug0_word;
  logic [31:0] read_word;
  cp_rsp_t     rsp_d;
  cp_rsp_t     rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // trace option strap: two-stage synchroniser, then a configuration register reloaded every edge
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trace_meta_q <= CFG_RST;
      trace_sync_q <= CFG_RST;
    end else begin
      trace_meta_q <= trace_macrocell_option_in;
      trace_sync_q <= trace_meta_q;
    end
  end

  // configuration copy read by the word builder
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trace_cfg_q <= CFG_RST;
    end else begin
      trace_cfg_q <= trace_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access decode and privilege check
  feature_access_check u_check (
    .req_in    (req_in),
    .sel_out   (sel),
    .hit_out   (hit),
    .undef_out (undef)
  );

  ////////////////////////////////////////////////////////////////////////////
  // feature word values
  feature_words u_words (
    .trace_on_in     (trace_cfg_q),
    .proc1_word_out  (proc1_word),
    .debug0_word_out (debug0_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data select; security state takes no part
  always_comb begin
    unique case (sel)
      SEL_PROC1:  read_word = proc1_word;
      SEL_DEBUG0: read_word = debug0_word;
      SEL_NONE:   read_word = RSP_DATA_RST;
      default:    read_word = RSP_DATA_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next answer: data only on a legal read, undefined flags the exception
  always_comb begin
    rsp_d       = '0;
    rsp_d.valid = req_in.valid;
    rsp_d.hit   = hit;
    rsp_d.undef = undef;
    rsp_d.data  = (hit && !undef) ? read_word : RSP_DATA_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer register
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_out = rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  // legal read of processor_feature_1 is granted with zero reserved bits and the fixed microcontroller field
  proc1_value_a: assert property (
    (sel == SEL_PROC1) && req_in.priv && !req_in.write
    |=> rsp_out.valid && rsp_out.hit && !rsp_out.undef
        && rsp_out.data[31:PF1_RSVD_LSB] == '0
        && rsp_out.data[PF1_MCU_LSB +: 4] == PF1_MCU_VAL)
    else $error("processor feature word reserved or mcu field wrong");

  // security and programmer's model fields
  proc1_fields_a: assert property (
    (sel == SEL_PROC1) && req_in.priv && !req_in.write
    |=> rsp_out.data[PF1_SEC_LSB +: 4] == PF1_SEC_VAL
        && rsp_out.data[PF1_PROG_LSB +: 4] == PF1_PROG_VAL)
    else $error("processor feature security or model field wrong");

  // fixed fields of debug_feature_0
  debug_fixed_a: assert property (
    (sel == SEL_DEBUG0) && req_in.priv && !req_in.write
    |=> !rsp_out.undef
        && rsp_out.data[31:DF0_MCU_LSB] == '0
        && rsp_out.data[DF0_CP_TRACE_LSB +: 4] == DF0_CP_TRACE_VAL
        && rsp_out.data[DF0_MM_CORE_LSB +: 4] == DF0_MM_CORE_VAL
        && rsp_out.data[DF0_CP_SEC_LSB +: 4] == DF0_CP_SEC_VAL
        && rsp_out.data[DF0_CP_CORE_LSB +: 4] == DF0_CP_CORE_VAL)
    else $error("debug feature fixed fields wrong");

  // trace field follows the synchronised strap
  trace_field_a: assert property (
    (sel == SEL_DEBUG0) && req_in.priv && !req_in.write
    |=> rsp_out.data[DF0_MM_TRACE_LSB +: 4]
        == ($past(trace_cfg_q) ? DF0_MM_TRACE_ON : DF0_MM_TRACE_OFF))
    else $error("trace field does not match the option");

  // strap reaches the configuration three edges later; judged only once reset
  // has been gone for three edges, as the chain restarts from zero after reset
  strap_sync_a: assert property (
    $past(nrst_in, 1) && $past(nrst_in, 2) && $past(nrst_in, 3)
    |-> trace_cfg_q == $past(trace_macrocell_option_in, 3))
    else $error("trace option not carried through");

  // user mode access of either register is refused without data
  user_refused_a: assert property (
    hit && !req_in.priv
    |=> rsp_out.valid && rsp_out.undef && rsp_out.data == RSP_DATA_RST)
    else $error("user mode access not refused");

  // every write is refused, privileged included
  write_refused_a: assert property (
    hit && req_in.write |=> rsp_out.undef && rsp_out.data == RSP_DATA_RST)
    else $error("write to feature register not refused");

  // back-to-back reads across a security change return the same word
  secure_same_a: assert property (
    hit && req_in.priv && !req_in.write
    ##1 (sel == $past(sel)) && req_in.priv && !req_in.write
        && (req_in.secure != $past(req_in.secure)) && !$changed(trace_cfg_q)
    |=> rsp_out.data == $past(rsp_out.data))
    else $error("word differs between security states");

  // other coprocessor coordinates are left alone
  miss_quiet_a: assert property (
    req_in.valid && !hit |=> rsp_out.valid && !rsp_out.hit && !rsp_out.undef)
    else $error("foreign access claimed");

  // no request, no answer
  idle_quiet_a: assert property (
    !req_in.valid |=> !rsp_out.valid && !rsp_out.hit && !rsp_out.undef)
    else $error("answer without request");

  // every request is answered exactly one edge later
  answer_follows_a: assert property (
    req_in.valid |=> rsp_out.valid)
    else $error("request left without answer");

  // the two coordinate sets are always claimed
  claim_coords_a: assert property (
    req_in.valid && req_in.crn == CRN_ID_GROUP && req_in.opc1 == OPC1_SYSTEM
        && req_in.crm == CRM_FEATURE
        && (req_in.opc2 == OPC2_PROC_FEAT1 || req_in.opc2 == OPC2_DEBUG_FEAT)
    |=> rsp_out.valid && rsp_out.hit)
    else $error("feature register access not claimed");

  // privileged reads are granted in both security states
  priv_read_ok_a: assert property (
    hit && req_in.priv && !req_in.write
    |=> rsp_out.valid && rsp_out.hit && !rsp_out.undef)
    else $error("privileged read refused");

  // a refused access never carries data
  refused_no_data_a: assert property (
    rsp_out.undef |-> rsp_out.valid && rsp_out.hit && rsp_out.data == RSP_DATA_RST)
    else $error("refused access carries data or no claim");

  // non-zero data only on a granted read
  data_needs_read_a: assert property (
    rsp_out.data != RSP_DATA_RST |-> rsp_out.valid && rsp_out.hit && !rsp_out.undef)
    else $error("data on an answer that is not a granted read");

  // a claim flag never stands without an answer
  hit_needs_valid_a: assert property (
    rsp_out.hit |-> rsp_out.valid)
    else $error("claim without answer");

  // foreign and idle cycles show zero data
  miss_no_data_a: assert property (
    !hit |=> rsp_out.data == RSP_DATA_RST)
    else $error("data on an unclaimed cycle");

  // whole processor_feature_1 word, same in either security state
  proc1_word_a: assert property (
    (sel == SEL_PROC1) && req_in.priv && !req_in.write
    |=> rsp_out.data == {20'h0_0000, PF1_MCU_VAL, PF1_SEC_VAL, PF1_PROG_VAL})
    else $error("processor feature word wrong");

  // reserved byte and microcontroller field of debug_feature_0
  debug_rsvd_a: assert property (
    (sel == SEL_DEBUG0) && req_in.priv && !req_in.write
    |=> rsp_out.valid && rsp_out.hit
        && rsp_out.data[31:DF0_RSVD_LSB] == '0
        && rsp_out.data[DF0_MCU_LSB +: 4] == DF0_MCU_VAL)
    else $error("debug feature reserved or mcu field wrong");

  // whole debug_feature_0 word, same in either security state
  debug_word_a: assert property (
    (sel == SEL_DEBUG0) && req_in.priv && !req_in.write
    |=> rsp_out.data == {8'h00, DF0_MCU_VAL,
                         ($past(trace_cfg_q) ? DF0_MM_TRACE_ON : DF0_MM_TRACE_OFF),
                         DF0_CP_TRACE_VAL, DF0_MM_CORE_VAL, DF0_CP_SEC_VAL, DF0_CP_CORE_VAL})
    else $error("debug feature word wrong");

  ////////////////////////////////////////////////////////////////////////////
  // scenarios of interest
  cov_secure_read_c: cover property (
    (sel == SEL_PROC1) && req_in.priv && req_in.secure && !req_in.write);
  cov_debug_trace_c: cover property (
    (sel == SEL_DEBUG0) && req_in.priv && !req_in.write && trace_cfg_q);
  cov_user_write_c: cover property (hit && req_in.write && !req_in.priv);
  cov_back_to_back_c: cover property (hit ##1 hit);
  cov_user_read_c: cover property (hit && !req_in.priv && !req_in.write);

endmodule // feature_id_regs

// >>> verification/test_processor_debug_feature_id_regs.sv
// Purpose: self-checking bench for the feature id register pair
// Assumes: fixed one-cycle answer; inputs driven 1 ns after the rising edge
// Notes:   no checker file, the assertions live in the design
`timescale 1ns/1ns
module test_processor_debug_feature_id_regs;
  import feature_id_pkg::*;

  logic    mclk_in;
  logic    nrst_in;
  logic    trace_macrocell_option_in;
  cp_req_t req_in;
  cp_rsp_t rsp_out;
  int      err_total;
  int      tests_run;

  feature_id_regs dut_u (
    .mclk_in                   (mclk_in),
    .nrst_in                   (nrst_in),
    .trace_macrocell_option_in (trace_macrocell_option_in),
    .req_in                    (req_in),
    .rsp_out                   (rsp_out)
  );

  // core clock, 10 ns period
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic cp_req_t mk(input logic wr, input logic [3:0] crn, input logic [3:0] crm,
                                 input logic [2:0] opc1, input logic [2:0] opc2,
                                 input logic pv, input logic sc);
    cp_req_t r;
    r.valid = 1'b1;
    r.write = wr;
    r.crn = crn;
    r.crm = crm;
    r.opc1 = opc1;
    r.opc2 = opc2;
    r.priv = pv;
    r.secure = sc;
    return r;
  endfunction

  function automatic cp_rsp_t ans(input logic ht, input logic ud, input logic [31:0] dt);
    cp_rsp_t a;
    a.valid = 1'b1;
    a.hit = ht;
    a.undef = ud;
    a.data = dt;
    return a;
  endfunction

  // expected debug word for a given trace strap
  function automatic logic [31:0] dbg_word(input logic t);
    return t ? 32'h0001_0400 : 32'h0000_0400;
  endfunction

  task automatic chk(input cp_rsp_t got, input cp_rsp_t exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask

  // present one request for one edge, return just after the answering edge
  task automatic issue(input cp_req_t r);
    req_in = r;
    @(posedge mclk_in);
    #1;
  endtask

  task automatic idle(input int n);
    req_in = '0;
    repeat (n) begin
      @(posedge mclk_in);
      #1;
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  // reset with a live request: answer must stay clear
  task automatic t_reset();
    req_in = mk(1'b0, 4'h0, 4'h1, 3'h0, 3'h1, 1'b1, 1'b0);
    nrst_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    chk(rsp_out, '0);
    req_in = '0;
    nrst_in = 1'b1;
    idle(1);
    chk(rsp_out, '0);
  endtask

  // privileged reads in both security states, answer stands one cycle
  task automatic t_proc1_read();
    for (int s = 0; s < 2; s++) begin
      issue(mk(1'b0, 4'h0, 4'h1, 3'h0, 3'h1, 1'b1, s[0]));
      chk(rsp_out, ans(1'b1, 1'b0, 32'h0000_0011));
      idle(1);
      chk(rsp_out, '0);
    end
  endtask

  // debug word with the trace strap absent and present
  task automatic t_debug_strap();
    for (int t = 0; t < 2; t++) begin
      trace_macrocell_option_in = t[0];
      idle(5);
      for (int s = 0; s < 2; s++) begin
        issue(mk(1'b0, 4'h0, 4'h1, 3'h0, 3'h2, 1'b1, s[0]));
        chk(rsp_out, ans(1'b1, 1'b0, dbg_word(t[0])));
      end
    end
    idle(1);
  endtask

  // every mode and direction back to back on both registers
  task automatic t_modes();
    logic [31:0] w;
    logic        bad;
    for (int k = 0; k < 16; k++) begin
      bad = k[0] | ~k[1];
      w = k[3] ? dbg_word(1'b1) : 32'h0000_0011;
      issue(mk(k[0], 4'h0, 4'h1, 3'h0, k[3] ? 3'h2 : 3'h1, k[1], k[2]));
      chk(rsp_out, ans(1'b1, bad, bad ? 32'h0 : w));
    end
    idle(1);
  endtask

  // coordinates outside the pair are not claimed
  task automatic t_unmapped();
    cp_req_t r [6];
    r[0] = mk(1'b0, 4'h1, 4'h1, 3'h0, 3'h1, 1'b1, 1'b0);
    r[1] = mk(1'b0, 4'h0, 4'h0, 3'h0, 3'h1, 1'b1, 1'b1);
    r[2] = mk(1'b0, 4'h0, 4'h1, 3'h1, 3'h2, 1'b1, 1'b0);
    r[3] = mk(1'b0, 4'h0, 4'h1, 3'h0, 3'h0, 1'b1, 1'b0);
    r[4] = mk(1'b1, 4'h0, 4'h1, 3'h0, 3'h3, 1'b0, 1'b0);
    r[5] = mk(1'b0, 4'h0, 4'h1, 3'h0, 3'h7, 1'b1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      issue(r[i]);
      chk(rsp_out, ans(1'b0, 1'b0, 32'h0));
    end
    idle(1);
  endtask

  // second reset: strap held high, reflected once synchronised again
  task automatic t_mid_reset();
    t_reset();
    idle(3);
    issue(mk(1'b0, 4'h0, 4'h1, 3'h0, 3'h2, 1'b1, 1'b0));
    chk(rsp_out, ans(1'b1, 1'b0, dbg_word(1'b1)));
    idle(1);
  endtask

  // bound on the whole run
  initial begin
    repeat (5000) @(posedge mclk_in);
    err_total++;
    end_of_test();
  end

  // main sequence
  initial begin
    err_total = 0;
    tests_run = 0;
    nrst_in = 1'b0;
    trace_macrocell_option_in = 1'b0;
    req_in = '0;
    #1;
    t_reset();
    idle(4);
    t_proc1_read();
    t_debug_strap();
    t_modes();
    t_unmapped();
    t_mid_reset();
    end_of_test();
  end

endmodule // test_processor_debug_feature_id_regs
